// File: volt_memory_pkg.sv
// constants, types and register map of the voltage angle memory
package volt_memory_pkg;

  localparam int CLK_PERIOD_NS  = 100;
  localparam int PROG_CYCLE_US  = 5000;
  localparam int PROG_CYCLE_CYC = PROG_CYCLE_US * 1000 / CLK_PERIOD_NS;
  localparam int HOLD_UNIT_MS   = 10;
  localparam int TICKS_PER_UNIT = HOLD_UNIT_MS * 1000 / PROG_CYCLE_US;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_VTHR    = 8'h04;
  localparam logic [7:0] OFF_ITHR    = 8'h08;
  localparam logic [7:0] OFF_HOLD    = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_REFAMP  = 8'h14;
  localparam logic [7:0] OFF_FREQ    = 8'h18;
  localparam logic [7:0] OFF_REFANG0 = 8'h1C;

  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_CUR_BIT  = 1;
  localparam int CTRL_CTF_BIT  = 2;
  localparam int CTRL_F60_BIT  = 3;
  localparam int CTRL_USED_LSB = 4;
  localparam int STAT_FALLBACK = 6;

  localparam logic [7:0]  CTRL_RST = 8'h70;
  localparam logic [15:0] VTHR_MIN = 16'h00C8;
  localparam logic [15:0] VTHR_MAX = 16'h1388;
  localparam logic [15:0] VTHR_RST = 16'h07D0;
  localparam logic [15:0] ITHR_RST = 16'h03E8;
  localparam logic [15:0] HOLD_MIN = 16'h0002;
  localparam logic [15:0] HOLD_MAX = 16'h1388;
  localparam logic [15:0] HOLD_RST = 16'h0032;
  localparam logic [15:0] FREQ_50  = 16'h1388;
  localparam logic [15:0] FREQ_60  = 16'h1770;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // event flag positions, each gives an on and an off pulse
  localparam int EVF_ENABLED  = 0;
  localparam int EVF_LOW_V    = 1;
  localparam int EVF_HIGH_I   = 2;
  localparam int EVF_CT_TRACK = 3;
  localparam int EVF_IN_USE   = 4;
  localparam int EVF_BLOCKED  = 5;
  localparam int EVF_N        = 6;

  typedef struct packed {
    logic [2:0][15:0] volt;
    logic [2:0][15:0] ang;
    logic [2:0][15:0] cur;
  } meas_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_HOLD  = 3'b010,
    ST_SPENT = 3'b100
  } mem_state_t;

endpackage : volt_memory_pkg

// File: prog_cycle_tick.sv
// divider giving the one-cycle program cycle enable
`timescale 1ns/100ps
`default_nettype none
module prog_cycle_tick #(
  parameter int PERIOD = 50000
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  output logic      tick
);

  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
    end
  end

endmodule : prog_cycle_tick
`default_nettype wire

// File: voltage_angle_memory.sv
// voltage angle memory core with its AXI4-Lite register slave
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module voltage_angle_memory
  import volt_memory_pkg::*;
#(
  parameter int PROG_CYCLE = PROG_CYCLE_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire meas_t             meas,
  input  wire logic [15:0]       ct_freq,
  input  wire logic              block_pin,
  output logic                   mem_active,
  output logic [15:0]            held_voltage_reference,
  output logic [2:0][15:0]       held_angle,
  output logic                   unidir_fallback,
  output logic                   ct_track,
  output logic [15:0]            samp_freq,
  output logic [EVF_N-1:0]       evt_on,
  output logic [EVF_N-1:0]       evt_off
);

  logic             tick;
  logic [7:0]       ctrl_r;
  logic [15:0]      vthr_r;
  logic [15:0]      ithr_r;
  logic [15:0]      hold_r;
  logic             aw_got_r;
  logic             w_got_r;
  logic [7:0]       awaddr_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             wr_go;
  logic [31:0]      rd_data;
  logic             rd_err;
  logic             wr_err;
  logic [2:0]       blk_sync_r;
  logic             blk_stable_r;
  logic             blk_cyc_r;
  mem_state_t       st_r;
  logic [15:0]      hold_cnt_r;
  logic [15:0]      hold_lim;
  logic [2:0]       below;
  logic [2:0]       above;
  logic             low_v_c;
  logic             high_i_c;
  logic             enabled;
  logic             act_cond_c;
  logic             ct_track_c;
  logic [EVF_N-1:0] flags_c;
  logic [EVF_N-1:0] flags_r;

  prog_cycle_tick #(.PERIOD(PROG_CYCLE)) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) merge[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction : merge

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign wr_go         = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_err        = !(awaddr_r == OFF_CTRL || awaddr_r == OFF_VTHR ||
                           awaddr_r == OFF_ITHR || awaddr_r == OFF_HOLD);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= '0;
      wdata_r      <= '0;
      wstrb_r      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      vthr_r <= VTHR_RST;
      ithr_r <= ITHR_RST;
      hold_r <= HOLD_RST;
    end else if (wr_go) begin
      case (awaddr_r)
        OFF_CTRL: ctrl_r <= 8'(merge({24'h0, ctrl_r}, wdata_r, wstrb_r));
        OFF_VTHR: vthr_r <= clamp(16'(merge({16'h0, vthr_r}, wdata_r, wstrb_r)), VTHR_MIN, VTHR_MAX);
        OFF_ITHR: ithr_r <= 16'(merge({16'h0, ithr_r}, wdata_r, wstrb_r));
        OFF_HOLD: hold_r <= clamp(16'(merge({16'h0, hold_r}, wdata_r, wstrb_r)), HOLD_MIN, HOLD_MAX);
        default: ;
      endcase
    end
  end

  // read channel
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (s_axi_araddr)
      OFF_CTRL:   rd_data = {24'h0, ctrl_r};
      OFF_VTHR:   rd_data = {16'h0, vthr_r};
      OFF_ITHR:   rd_data = {16'h0, ithr_r};
      OFF_HOLD:   rd_data = {16'h0, hold_r};
      OFF_STATUS: rd_data = {25'h0, unidir_fallback, flags_r};
      OFF_REFAMP: rd_data = {16'h0, held_voltage_reference};
      OFF_FREQ:   rd_data = {16'h0, samp_freq};
      default:    rd_err  = 1'b1;
    endcase
    for (int k = 0; k < 3; k++) begin
      if (s_axi_araddr == OFF_REFANG0 + 8'(4 * k)) begin
        rd_data = {16'h0, held_angle[k]};
        rd_err  = 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // block pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      blk_sync_r   <= '0;
      blk_stable_r <= 1'b0;
      blk_cyc_r    <= 1'b0;
    end else begin
      blk_sync_r <= {blk_sync_r[1:0], block_pin};
      if (blk_sync_r[1] == blk_sync_r[2]) blk_stable_r <= blk_sync_r[2];
      if (tick) blk_cyc_r <= blk_stable_r;
    end
  end

  // detection conditions
  generate
    for (genvar k = 0; k < 3; k++) begin : g_phase
      assign below[k] = (meas.volt[k] < vthr_r) || !ctrl_r[CTRL_USED_LSB + k];
      assign above[k] = meas.cur[k] > ithr_r;
    end
  endgenerate

  assign enabled    = ctrl_r[CTRL_EN_BIT];
  assign low_v_c    = (&below) && (|ctrl_r[CTRL_USED_LSB +: 3]);
  assign high_i_c   = |above;
  assign act_cond_c = enabled && !blk_stable_r && low_v_c && (!ctrl_r[CTRL_CUR_BIT] || high_i_c);
  assign ct_track_c = enabled && ctrl_r[CTRL_CTF_BIT] && low_v_c;
  assign hold_lim   = 16'(hold_r * TICKS_PER_UNIT);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r       <= ST_IDLE;
      hold_cnt_r <= '0;
    end else if (tick) begin
      case (st_r)
        ST_IDLE: begin
          hold_cnt_r <= '0;
          if (act_cond_c) st_r <= ST_HOLD;
        end
        ST_HOLD: begin
          if (!enabled || blk_stable_r || !low_v_c) st_r <= ST_IDLE;
          else if (hold_cnt_r >= hold_lim - 16'd1) st_r <= ST_SPENT;
          else hold_cnt_r <= hold_cnt_r + 16'd1;
        end
        ST_SPENT: begin
          if (!enabled || !low_v_c) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign mem_active             = (st_r == ST_HOLD);
  assign unidir_fallback        = (st_r == ST_SPENT);
  assign held_voltage_reference = mem_active ? vthr_r : '0;

  // angles update only in idle and freeze once all used voltages are low, hence they are pre-fault values
  always_ff @(posedge ref_clk) begin
    if (!rst_n) held_angle <= '0;
    else if (tick && st_r == ST_IDLE && !low_v_c) held_angle <= meas.ang;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ct_track  <= 1'b0;
      samp_freq <= FREQ_50;
    end else begin
      ct_track  <= ct_track_c;
      samp_freq <= ct_track_c ? ct_freq : (ctrl_r[CTRL_F60_BIT] ? FREQ_60 : FREQ_50);
    end
  end

  // event pulses, judged once per program cycle
  assign flags_c = {blk_stable_r, mem_active, ct_track_c, high_i_c, low_v_c, enabled};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) flags_r <= '0;
    else if (tick) flags_r <= flags_c;
  end

  generate
    for (genvar f = 0; f < EVF_N; f++) begin : g_evt
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          evt_on[f]  <= 1'b0;
          evt_off[f] <= 1'b0;
        end else begin
          evt_on[f]  <= tick && flags_c[f] && !flags_r[f];
          evt_off[f] <= tick && !flags_c[f] && flags_r[f];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_low_v_all: assert property ($rose(mem_active) |-> $past(low_v_c && tick))
    else $error("memory rose without all voltages low");
  a_cur_gate: assert property ($rose(mem_active) && ctrl_r[CTRL_CUR_BIT] |-> $past(high_i_c))
    else $error("memory rose without current pickup");
  a_thr_range: assert property (vthr_r >= VTHR_MIN && vthr_r <= VTHR_MAX)
    else $error("activation threshold out of range");
  a_ref_amp: assert property (mem_active |-> held_voltage_reference == vthr_r && vthr_r != 16'h0)
    else $error("reference amplitude is not the threshold");
  a_angle_frozen: assert property (mem_active && $past(mem_active) |-> $stable(held_angle))
    else $error("held angle moved while active");
  a_block_cycle: assert property (!tick |=> $stable(blk_cyc_r))
    else $error("block sample changed between program cycles");
  a_hold_bound: assert property (mem_active |-> hold_cnt_r < hold_lim)
    else $error("hold counter beyond its limit");
  a_fallback_cause: assert property ($rose(unidir_fallback) |-> $past(mem_active && hold_cnt_r == hold_lim - 16'd1))
    else $error("fallback without expiry");
  a_fixed_freq: assert property (!$past(ct_track_c) |-> samp_freq == FREQ_50 || samp_freq == FREQ_60)
    else $error("fixed frequency not used");
  a_ct_freq: assert property (ct_track |-> samp_freq == $past(ct_freq))
    else $error("sampling does not follow the current channel");
  a_evt_pair: assert property ((evt_on & evt_off) == '0)
    else $error("event on and off pulse together");
  a_evt_tick: assert property ((|evt_on) || (|evt_off) |-> $past(tick))
    else $error("event pulse outside a program cycle");
  a_drop_cause: assert property ($fell(mem_active) |->
    $past(tick && (!enabled || blk_stable_r || !low_v_c || hold_cnt_r >= hold_lim - 16'd1)))
    else $error("memory dropped without cause");
  a_angle_track: assert property (tick && st_r == ST_IDLE && !low_v_c |=> held_angle == $past(meas.ang))
    else $error("idle angles not tracking");

  c_activate: cover property (st_r == ST_IDLE ##1 st_r == ST_HOLD);
  c_expire:   cover property (st_r == ST_HOLD ##1 st_r == ST_SPENT);
  c_ct_track: cover property ($rose(ct_track));
  c_blocked:  cover property (evt_on[EVF_BLOCKED]);

endmodule : voltage_angle_memory
`default_nettype wire

// File: stage_model.sv
// far-side protection stage model consuming the held reference
`timescale 1ns/100ps
`default_nettype none
module stage_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        mem_active,
  input  wire logic [15:0] ref_amp,
  input  wire logic        fallback,
  output logic [1:0]       stage_mode,
  output logic [15:0]      seen_amp
);
  // mode 0 measured, 1 memory reference, 2 unidirectional
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage_mode <= 2'h0;
      seen_amp   <= 16'h0000;
    end else begin
      stage_mode <= fallback ? 2'h2 : (mem_active ? 2'h1 : 2'h0);
      if (mem_active) begin
        seen_amp <= ref_amp;
      end
    end
  end
endmodule : stage_model
`default_nettype wire

// File: testbench.sv
// self-checking bench for the voltage angle memory
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import volt_memory_pkg::*;
  localparam int PC = 20;
  localparam int LIMIT = 5000;
  localparam logic [15:0] VT = 16'h01F4;
  logic ref_clk = 1'b0, rst_n = 1'b0, block_pin = 1'b0, clr_ev = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, stage_mode;
  logic [31:0] s_axi_rdata;
  meas_t meas = '0;
  logic [15:0] ct_freq = 16'h1388, held_voltage_reference, samp_freq, seen_amp;
  logic [2:0][15:0] held_angle;
  logic mem_active, unidir_fallback, ct_track;
  logic [EVF_N-1:0] evt_on, evt_off, seen_on = '0, seen_off = '0;
  int mismatches = 0, check_count = 0, cyc = 0;

  voltage_angle_memory #(.PROG_CYCLE(PC)) u_dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas, .ct_freq, .block_pin, .mem_active,
    .held_voltage_reference, .held_angle, .unidir_fallback, .ct_track, .samp_freq, .evt_on, .evt_off);
  stage_model u_stage (.ref_clk(ref_clk), .rst_n(rst_n), .mem_active(mem_active),
    .ref_amp(held_voltage_reference), .fallback(unidir_fallback), .stage_mode(stage_mode),
    .seen_amp(seen_amp));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    seen_on  <= clr_ev ? evt_on : (seen_on | evt_on);
    seen_off <= clr_ev ? evt_off : (seen_off | evt_off);
    cyc      <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] clampv(input logic [15:0] v);
    return (v < VTHR_MIN) ? VTHR_MIN : ((v > VTHR_MAX) ? VTHR_MAX : v);
  endfunction : clampv

  function automatic logic [15:0] exp_freq(input logic [7:0] c);
    return c[CTRL_F60_BIT] ? FREQ_60 : FREQ_50;
  endfunction : exp_freq

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_bvalid === 1'b1) begin
        chk(s_axi_bresp, er, "write resp");
        s_axi_bready <= 1'b0;
        break;
      end
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge ref_clk);
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string msg);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(r, RESP_OKAY, msg);
    chk(d, e, msg);
  endtask : rchk

  task automatic tk(input int n);
    repeat (n * PC) @(posedge ref_clk);
  endtask : tk

  task automatic ev_clear();
    clr_ev <= 1'b1;
    @(posedge ref_clk);
    clr_ev <= 1'b0;
  endtask : ev_clear

  task automatic wait_act(input logic v);
    int n;
    n = 0;
    while (mem_active !== v && n < 3 * PC) begin
      @(posedge ref_clk);
      n++;
    end
    chk(mem_active, v, "memory active");
  endtask : wait_act

  task automatic setv(input logic low);
    for (int i = 0; i < 3; i++)
      meas.volt[i] <= low ? 16'($urandom_range(VT - 1)) : 16'(VT + 1 + $urandom_range(3000));
  endtask : setv

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0][15:0] pre;
    logic [15:0] vt_tab [4];
    vt_tab = '{16'h0001, 16'h1389, 16'h00C8, VT};
    void'($urandom(32'hA66C));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(samp_freq, FREQ_50, "reset freq");
    rchk(OFF_CTRL, CTRL_RST, "ctrl reset");
    rchk(OFF_ITHR, ITHR_RST, "ithr reset");
    rchk(OFF_HOLD, HOLD_RST, "hold reset");
    rd(8'h40, d, r);
    chk({d, r}, {32'h0, RESP_SLVERR}, "unmapped read");
    wr(OFF_STATUS, 32'h3F, RESP_SLVERR);
    foreach (vt_tab[i]) begin
      wr(OFF_VTHR, vt_tab[i], RESP_OKAY);
      rchk(OFF_VTHR, clampv(vt_tab[i]), "vthr clamp");
    end
    wr(OFF_HOLD, 32'h1, RESP_OKAY);
    rchk(OFF_HOLD, HOLD_MIN, "hold clamp");
    setv(1'b0);
    meas.ang <= 48'($urandom()) ^ {$urandom(), 16'h0};
    ev_clear();
    wr(OFF_CTRL, 32'h71, RESP_OKAY);
    tk(2);
    chk(held_angle, meas.ang, "angle track");
    chk(seen_on[EVF_ENABLED], 1'b1, "enable event");
    chk(samp_freq, exp_freq(8'h71), "fixed 50");
    meas.volt <= {VT, 16'h0, 16'h0};
    tk(2);
    chk(mem_active, 1'b0, "one at threshold");
    pre = meas.ang;
    setv(1'b1);
    meas.ang <= ~pre;
    ev_clear();
    wait_act(1'b1);
    chk(held_voltage_reference, VT, "ref amp");
    chk(held_angle, pre, "pre-fault angle");
    chk(unidir_fallback, 1'b0, "no early fallback");
    rchk(OFF_REFAMP, VT, "refamp reg");
    tk(2);
    chk({mem_active, stage_mode, seen_amp}, {1'b1, 2'h1, VT}, "stage sees memory");
    chk(seen_on[EVF_LOW_V] & seen_on[EVF_IN_USE], 1'b1, "use events");
    tk(4);
    chk({mem_active, unidir_fallback, stage_mode}, {1'b0, 1'b1, 2'h2}, "hold expiry");
    chk({held_voltage_reference, seen_off[EVF_IN_USE]}, {16'h0, 1'b1}, "memory released");
    rd(OFF_STATUS, d, r);
    chk(d[STAT_FALLBACK], 1'b1, "status fallback");
    ev_clear();
    setv(1'b0);
    tk(2);
    chk({unidir_fallback, seen_off[EVF_LOW_V]}, 2'b01, "recovery");
    setv(1'b1);
    wait_act(1'b1);
    ev_clear();
    block_pin <= 1'b1;
    tk(2);
    chk({mem_active, seen_on[EVF_BLOCKED]}, 2'b01, "blocked");
    block_pin <= 1'b0;
    setv(1'b0);
    tk(2);
    chk(seen_off[EVF_BLOCKED], 1'b1, "unblocked");
    wr(OFF_CTRL, 32'h73, RESP_OKAY);
    for (int i = 0; i < 3; i++)
      meas.cur[i] <= 16'($urandom_range(999));
    setv(1'b1);
    tk(3);
    chk(mem_active, 1'b0, "low current");
    ev_clear();
    meas.cur[2] <= 16'(ITHR_RST + 1 + $urandom_range(500));
    wait_act(1'b1);
    tk(2);
    chk(seen_on[EVF_HIGH_I], 1'b1, "current event");
    setv(1'b0);
    meas.cur <= '0;
    tk(2);
    chk(mem_active, 1'b0, "voltage back");
    wr(OFF_CTRL, 32'h79, RESP_OKAY);
    tk(2);
    chk(samp_freq, exp_freq(8'h79), "fixed 60");
    rchk(OFF_FREQ, FREQ_60, "freq reg");
    wr(OFF_CTRL, 32'h75, RESP_OKAY);
    ct_freq <= 16'(4500 + $urandom_range(2000));
    ev_clear();
    setv(1'b1);
    tk(2);
    chk({ct_track, samp_freq}, {1'b1, ct_freq}, "ct tracking");
    setv(1'b0);
    tk(2);
    chk({ct_track, seen_on[EVF_CT_TRACK], seen_off[EVF_CT_TRACK]}, 3'b011, "ct events");
    wr(OFF_CTRL, 32'h11, RESP_OKAY);
    meas.volt <= {16'h1388, 16'h1388, 16'h0000};
    wait_act(1'b1);
    wr(OFF_CTRL, 32'h01, RESP_OKAY);
    tk(2);
    chk(mem_active, 1'b0, "no voltage in use");
    ev_clear();
    wr(OFF_CTRL, 32'h70, RESP_OKAY);
    tk(2);
    chk(seen_off[EVF_ENABLED], 1'b1, "disable event");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
